// ==== hdl/b2ds_pkg.sv ====
/*
  constants for the two-word-burst double-data-rate sram port.
  assumes one reference clock well faster than the memory input clocks.
*/
// Operation
// - write: load low, read-not-write low at K rise; beats at K then K_N next cycle
// - read: load low, read-not-write high; first word 2.5 cycles later, second next
// - every transaction moves two words, array words {A,0} then {A,1}
// - write data captured and read data launched on both K and K_N rises
// - stopped clocks: no operation, data pins hold their previous state
// - after power-up the port is deselected, data outputs high impedance
// - 18-bit mode: mask bit 0 gates bits 8..0, bit 1 gates 17..9
// - 36-bit mode: four active-low mask bits gate the four 9-bit lanes
// - all mask bits high: that beat writes nothing, transaction still completes
// - masks sampled separately with each beat, may differ between beats
// - no read issued: finish pending beats, tri-state after next K_N rise
// - read of just-written address returns newest data, not stale array contents
package b2ds_pkg;
  localparam int SYNC_STAGES = 3;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int ADDR_W = 19;
  localparam int WBUF_DEPTH = 4;
  localparam int REF_CLK_PERIOD_NS = 25;
  localparam logic RD_CMD = 1'h1;
  localparam logic LOAD_ACTIVE = 1'h0;
  localparam logic BEAT_FIRST = 1'h0;
  localparam logic BEAT_SECOND = 1'h1;
endpackage : b2ds_pkg

// ==== hdl/b2ds_fifo.sv ====
/*
  small synchronous fifo with valid/ready on both sides.
  assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module b2ds_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = store[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
    end
    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset
  always_ff @(posedge clk) begin
    if (push) begin
      store[wp_r] <= in_data;
    end
  end
endmodule : b2ds_fifo
`default_nettype wire

// ==== hdl/b2ds_port.sv ====
/*
  command and data port of a two-word-burst double-data-rate sram,
  with its storage array. the input clock pair and all pins are sampled
  on REF_CLK; each half period of K must span at least eight REF_CLK cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module b2ds_port #(
  parameter int DATA_W = b2ds_pkg::DATA_W,
  parameter int ADDR_W = b2ds_pkg::ADDR_W,
  parameter int WBUF_DEPTH = b2ds_pkg::WBUF_DEPTH
) (
  // reference clock and power-up reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // memory input clocks
  input wire logic K,
  input wire logic K_N,
  // command
  input wire logic [ADDR_W-1:0] A,
  input wire logic ADDRESS_LOAD_N,
  input wire logic READ_NOT_WRITE,
  input wire logic [DATA_W/b2ds_pkg::LANE_W-1:0] BYTE_WRITE_MASK_N,
  // data pins
  input wire logic [DATA_W-1:0] DQ_IN,
  output logic [DATA_W-1:0] DQ_OUT,
  output logic DQ_OE,
  // write buffer status
  output logic WBUF_READY
);
  localparam int LANES = DATA_W / b2ds_pkg::LANE_W;
  localparam int SW = 2 + ADDR_W + 2 + LANES + DATA_W;
  localparam int WA = ADDR_W + 1;
  localparam int EW = WA + LANES + DATA_W;
  // pins at rest: K low, K_N high, so no false edge follows reset
  localparam logic [SW-1:0] SYNC_IDLE = {2'h1, {(SW-2){1'h0}}};

  typedef enum logic [3:0] {
    F_IDLE = 4'h1,
    F_WAIT = 4'h2,
    F_RD0 = 4'h4,
    F_RD1 = 4'h8
  } b2ds_fetch_e;

  // ---------------- pin sampling
  logic [SW-1:0] s1_r, s2_r, s3_r;
  logic [SW-1:0] s1_nxt, s2_nxt, s3_nxt;
  logic k_lvl_r, k_lvl_nxt, kn_lvl_r, kn_lvl_nxt;
  logic k_rise, kn_rise;
  logic [ADDR_W-1:0] a_s;
  logic ld_n_s, rw_s;
  logic [LANES-1:0] msk_s;
  logic [DATA_W-1:0] d_s;

  always_comb begin
    s1_nxt = {K, K_N, A, ADDRESS_LOAD_N, READ_NOT_WRITE, BYTE_WRITE_MASK_N, DQ_IN};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    k_lvl_nxt = (s2_r[SW-1] == s3_r[SW-1]) ? s3_r[SW-1] : k_lvl_r;
    kn_lvl_nxt = (s2_r[SW-2] == s3_r[SW-2]) ? s3_r[SW-2] : kn_lvl_r;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
      s3_r <= SYNC_IDLE;
      k_lvl_r <= 1'b0;
      kn_lvl_r <= 1'b1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      k_lvl_r <= k_lvl_nxt;
      kn_lvl_r <= kn_lvl_nxt;
    end
  end

  // edges only while clocks toggle; stopped clocks freeze commands and outputs, but the write buffer still drains
  assign k_rise = k_lvl_nxt & ~k_lvl_r;
  assign kn_rise = kn_lvl_nxt & ~kn_lvl_r;
  assign d_s = s3_r[DATA_W-1:0];
  assign msk_s = s3_r[DATA_W +: LANES];
  assign rw_s = s3_r[DATA_W + LANES];
  assign ld_n_s = s3_r[DATA_W + LANES + 1];
  assign a_s = s3_r[DATA_W + LANES + 2 +: ADDR_W];

  // ---------------- command pipeline and write beat capture
  logic wr_iss_r, wr_iss_nxt, wr_b2_r, wr_b2_nxt;
  logic [ADDR_W-1:0] wr_a_r, wr_a_nxt, wr_b2a_r, wr_b2a_nxt;
  logic rd_p1_r, rd_p1_nxt, rd_p2_r, rd_p2_nxt, rd_p3_r, rd_p3_nxt;
  logic [ADDR_W-1:0] rd_a_r, rd_a_nxt, rd_a1_r, rd_a1_nxt, rd_a2_r, rd_a2_nxt;
  logic push_v;
  logic [EW-1:0] push_d;

  always_comb begin
    wr_iss_nxt = wr_iss_r;
    wr_a_nxt = wr_a_r;
    wr_b2_nxt = wr_b2_r;
    wr_b2a_nxt = wr_b2a_r;
    rd_p1_nxt = rd_p1_r;
    rd_p2_nxt = rd_p2_r;
    rd_p3_nxt = rd_p3_r;
    rd_a_nxt = rd_a_r;
    rd_a1_nxt = rd_a1_r;
    rd_a2_nxt = rd_a2_r;
    push_v = 1'b0;
    push_d = '0;
    if (k_rise) begin
      wr_iss_nxt = (ld_n_s == b2ds_pkg::LOAD_ACTIVE) && (rw_s != b2ds_pkg::RD_CMD);
      wr_a_nxt = a_s;
      rd_p1_nxt = (ld_n_s == b2ds_pkg::LOAD_ACTIVE) && (rw_s == b2ds_pkg::RD_CMD);
      rd_a_nxt = a_s;
      rd_p2_nxt = rd_p1_r;
      rd_a1_nxt = rd_a_r;
      // read address two K rises back, steady through the fetch
      rd_a2_nxt = rd_a1_r;
      rd_p3_nxt = rd_p2_r;
      wr_b2_nxt = wr_iss_r;
      wr_b2a_nxt = wr_a_r;
      // first beat at K rise one cycle after the command, own mask
      push_v = wr_iss_r;
      push_d = {wr_a_r, b2ds_pkg::BEAT_FIRST, msk_s, d_s};
    end else if (kn_rise && wr_b2_r) begin
      wr_b2_nxt = 1'b0;
      push_v = 1'b1;
      push_d = {wr_b2a_r, b2ds_pkg::BEAT_SECOND, msk_s, d_s};
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_iss_r <= 1'b0;
      wr_a_r <= '0;
      wr_b2_r <= 1'b0;
      wr_b2a_r <= '0;
      rd_p1_r <= 1'b0;
      rd_p2_r <= 1'b0;
      rd_p3_r <= 1'b0;
      rd_a_r <= '0;
      rd_a1_r <= '0;
      rd_a2_r <= '0;
    end else begin
      wr_iss_r <= wr_iss_nxt;
      wr_a_r <= wr_a_nxt;
      wr_b2_r <= wr_b2_nxt;
      wr_b2a_r <= wr_b2a_nxt;
      rd_p1_r <= rd_p1_nxt;
      rd_p2_r <= rd_p2_nxt;
      rd_p3_r <= rd_p3_nxt;
      rd_a_r <= rd_a_nxt;
      rd_a1_r <= rd_a1_nxt;
      rd_a2_r <= rd_a2_nxt;
    end
  end

  // ---------------- write buffer and array
  logic fv, fr;
  logic [EW-1:0] fd;
  logic [DATA_W-1:0] mem [2**WA];
  logic [DATA_W-1:0] bit_en;
  logic [WA-1:0] f_addr;
  logic [LANES-1:0] f_msk_n;
  logic [DATA_W-1:0] f_dat;

  b2ds_fifo #(.WIDTH(EW), .DEPTH(WBUF_DEPTH)) u_wbuf (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .in_valid(push_v),
    .in_ready(WBUF_READY),
    .in_data(push_d),
    .out_valid(fv),
    .out_ready(fr),
    .out_data(fd)
  );

  assign f_addr = fd[EW-1 -: WA];
  assign f_msk_n = fd[DATA_W +: LANES];
  assign f_dat = fd[DATA_W-1:0];

  // lane enables, one 9-bit lane per active-low mask bit
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      assign bit_en[gl*b2ds_pkg::LANE_W +: b2ds_pkg::LANE_W] =
        {b2ds_pkg::LANE_W{~f_msk_n[gl]}};
    end
  endgenerate

  // masked-off lanes keep contents; an all-high mask leaves the word unchanged
  always_ff @(posedge REF_CLK) begin
    if (fv && fr) begin
      mem[f_addr] <= (mem[f_addr] & ~bit_en) | (f_dat & bit_en);
    end
  end

  // ---------------- read fetch
  b2ds_fetch_e st_r, st_nxt;
  logic [DATA_W-1:0] buf0_r, buf0_nxt, buf1_r, buf1_nxt;

  // array port is lent to the fetch, so the drain stalls there
  assign fr = (st_r != F_RD0) && (st_r != F_RD1);

  always_comb begin
    st_nxt = st_r;
    buf0_nxt = buf0_r;
    buf1_nxt = buf1_r;
    unique case (st_r)
      F_IDLE: begin
        if (k_rise && rd_p2_r) begin
          st_nxt = F_WAIT;
        end
      end
      F_WAIT: begin
        // pending writes land first so the newest data is returned
        if (!fv && !push_v) begin
          st_nxt = F_RD0;
        end
      end
      F_RD0: begin
        buf0_nxt = mem[{rd_a2_r, b2ds_pkg::BEAT_FIRST}];
        st_nxt = F_RD1;
      end
      F_RD1: begin
        buf1_nxt = mem[{rd_a2_r, b2ds_pkg::BEAT_SECOND}];
        st_nxt = F_IDLE;
      end
      default: begin
        st_nxt = F_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= F_IDLE;
      buf0_r <= '0;
      buf1_r <= '0;
    end else begin
      st_r <= st_nxt;
      buf0_r <= buf0_nxt;
      buf1_r <= buf1_nxt;
    end
  end

  // ---------------- output launch
  logic [DATA_W-1:0] q_r, q_nxt;
  logic oe_r, oe_nxt;

  always_comb begin
    q_nxt = q_r;
    oe_nxt = oe_r;
    if (kn_rise) begin
      if (rd_p3_r) begin
        // first word at K_N rise two and a half cycles after the command
        q_nxt = buf0_r;
        oe_nxt = 1'b1;
      end else begin
        oe_nxt = 1'b0;
      end
    end else if (k_rise && rd_p3_r) begin
      q_nxt = buf1_r;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      q_r <= '0;
      oe_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign DQ_OUT = q_r;
  assign DQ_OE = oe_r;
endmodule : b2ds_port
`default_nettype wire

// ==== verif/b2ds_port_monitor.sv ====
/* pin-level checks of the sram port.
   assumes binding to b2ds_port and legal K phase lengths. */
`timescale 1ns/1ps
`default_nettype none
module b2ds_port_monitor #(
  parameter int DATA_W = 36
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // clocks and command
  input wire logic K,
  input wire logic K_N,
  input wire logic ADDRESS_LOAD_N,
  input wire logic READ_NOT_WRITE,
  // outputs
  input wire logic [DATA_W-1:0] DQ_OUT,
  input wire logic DQ_OE,
  input wire logic WBUF_READY
);
  logic k_r, kn_r, k_rise;
  logic [3:0] k_age_r, k_age_nxt, kn_age_r, kn_age_nxt, rd_hist_r, rd_hist_nxt;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // cycles since each clock pin rose, reads seen per K rise
  always_comb begin
    k_rise = K && !k_r;
    k_age_nxt = k_rise ? 4'h0 : k_age_r + 4'(k_age_r != 4'hf);
    kn_age_nxt = (K_N && !kn_r) ? 4'h0 : kn_age_r + 4'(kn_age_r != 4'hf);
    rd_hist_nxt = rd_hist_r;
    if (k_rise) begin
      rd_hist_nxt = {rd_hist_r[2:0], !ADDRESS_LOAD_N && READ_NOT_WRITE};
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      k_r <= 1'h0;
      kn_r <= 1'h1;
      k_age_r <= 4'hf;
      kn_age_r <= 4'hf;
      rd_hist_r <= 4'h0;
    end else begin
      k_r <= K;
      kn_r <= K_N;
      k_age_r <= k_age_nxt;
      kn_age_r <= kn_age_nxt;
      rd_hist_r <= rd_hist_nxt;
    end
  end
  a_reset_tristate: assert property ($rose(RST_B) |-> !DQ_OE && DQ_OUT == '0)
    else $error("outputs not idle after reset");
  a_wbuf_ready: assert property (WBUF_READY)
    else $error("write buffer refused a beat");
  a_stop_hold: assert property (($stable(K) && $stable(K_N)) [*8] |=> $stable(DQ_OUT) && $stable(DQ_OE))
    else $error("data pins moved with clocks stopped");
  a_oe_rise_kn: assert property ($rose(DQ_OE) |-> kn_age_r inside {[2:7]})
    else $error("drive began away from a K_N rise");
  a_out_edge: assert property (!$stable(DQ_OUT) |-> k_age_r <= 4'h7 || kn_age_r <= 4'h7)
    else $error("read data changed away from a clock rise");
  a_oe_fall_kn: assert property ($fell(DQ_OE) |-> kn_age_r inside {[2:7]})
    else $error("tri-state away from a K_N rise");
  a_read_latency: assert property ($rose(DQ_OE) |-> rd_hist_r[2])
    else $error("drive began without a read two cycles back");
  a_read_end: assert property (rd_hist_r[3:2] == 2'h0 |-> !DQ_OE)
    else $error("driving with no read pending");
  c_rd: cover property ($rose(DQ_OE));
  c_rd_end: cover property ($fell(DQ_OE));
  c_wr: cover property (k_rise && !ADDRESS_LOAD_N && !READ_NOT_WRITE);
endmodule : b2ds_port_monitor
bind b2ds_port b2ds_port_monitor #(.DATA_W(DATA_W)) i_b2ds_port_monitor (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .K(K), .K_N(K_N),
  .ADDRESS_LOAD_N(ADDRESS_LOAD_N), .READ_NOT_WRITE(READ_NOT_WRITE),
  .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .WBUF_READY(WBUF_READY));
`default_nettype wire

// ==== verif/b2ds_ctl_model.sv ====
/* memory controller model: makes K and K_N, drives commands and beats.
   assumes REF_CLK is the port's sampling clock; K low 9 cycles, other halves 10 or more. */
`timescale 1ns/1ps
`default_nettype none
module b2ds_ctl_model #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 6
) (
  // sampling clock
  input wire logic ref_clk,
  // pins toward the port
  output logic k,
  output logic k_n,
  output logic [ADDR_W-1:0] a,
  output logic ld_n,
  output logic rw,
  output logic [DATA_W/b2ds_pkg::LANE_W-1:0] mask_n,
  output logic [DATA_W-1:0] dq_in,
  // read side
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe
);
  logic [DATA_W-1:0] q_k, q_n;
  logic oe_k;
  initial begin
    k = 1'h0;
    k_n = 1'h1;
    a = '0;
    ld_n = 1'h1;
    rw = 1'h0;
    mask_n = '1;
    dq_in = '0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_n
  // one K period; beats belong to the write of the previous period
  // clocks rest both high between periods; a released bus reads back inverted
  task automatic kcyc(input logic l, input logic r, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] d0, input logic [3:0] m0,
      input logic [DATA_W-1:0] d1, input logic [3:0] m1);
    wait_n(1);
    k <= 1'h0;
    wait_n(4);
    a <= ad;
    ld_n <= l;
    rw <= r;
    dq_in <= d0;
    mask_n <= m0;
    wait_n(5);
    q_k = dq_oe ? dq_out : ~dq_out;
    oe_k = dq_oe;
    k <= 1'h1;
    k_n <= 1'h0;
    wait_n(5);
    dq_in <= d1;
    mask_n <= m1;
    wait_n(5);
    q_n = dq_oe ? dq_out : ~dq_out;
    k_n <= 1'h1;
  endtask : kcyc
endmodule : b2ds_ctl_model
`default_nettype wire

// ==== verif/tb_top.sv ====
/* self-checking bench of the sram port.
   assumes the controller model drives every port input except REF_CLK and RST_B. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [35:0] D0 = 36'h123456789;
  localparam logic [35:0] D1 = 36'hfedcba987;
  localparam logic [35:0] E0 = 36'h5a5a5a5a5;
  localparam logic [35:0] E1 = 36'h0f0f0f0f0;
  logic REF_CLK, RST_B, K, K_N, ADDRESS_LOAD_N, READ_NOT_WRITE, DQ_OE, WBUF_READY;
  logic [5:0] A;
  logic [3:0] BYTE_WRITE_MASK_N;
  logic [35:0] DQ_IN, DQ_OUT;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  b2ds_port #(.DATA_W(36), .ADDR_W(6), .WBUF_DEPTH(4)) i_b2ds_port (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .K(K), .K_N(K_N), .A(A),
    .ADDRESS_LOAD_N(ADDRESS_LOAD_N), .READ_NOT_WRITE(READ_NOT_WRITE),
    .BYTE_WRITE_MASK_N(BYTE_WRITE_MASK_N), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT),
    .DQ_OE(DQ_OE), .WBUF_READY(WBUF_READY));
  b2ds_ctl_model #(.DATA_W(36), .ADDR_W(6)) i_b2ds_ctl_model (
    .ref_clk(REF_CLK), .k(K), .k_n(K_N), .a(A), .ld_n(ADDRESS_LOAD_N),
    .rw(READ_NOT_WRITE), .mask_n(BYTE_WRITE_MASK_N), .dq_in(DQ_IN),
    .dq_out(DQ_OUT), .dq_oe(DQ_OE));
  initial begin
    REF_CLK = 1'h0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // idle cycle, data lines toggled so stale values never match
  task automatic idle;
    i_b2ds_ctl_model.kcyc(1'h1, 1'h0, 6'h00, ~DQ_IN, 4'hf, DQ_IN, 4'hf);
  endtask : idle
  // masked rewrite, reads straight after, clock stop mid-read
  task automatic test_merge_read;
    i_b2ds_ctl_model.kcyc(1'h0, 1'h0, 6'h05, E1, 4'hf, ~E1, 4'hf);
    i_b2ds_ctl_model.kcyc(1'h0, 1'h0, 6'h05, D0, 4'h0, D1, 4'h0);
    i_b2ds_ctl_model.kcyc(1'h0, 1'h1, 6'h05, E0, 4'he, E1, 4'hf);
    i_b2ds_ctl_model.kcyc(1'h0, 1'h1, 6'h05, ~E0, 4'hf, ~E1, 4'hf);
    idle();
    repeat (40) @(posedge REF_CLK);
    check(DQ_OUT, {D0[35:9], E0[8:0]});
    check(DQ_OE, 1'h1);
    idle();
    check(i_b2ds_ctl_model.q_k, {D0[35:9], E0[8:0]});
    check(i_b2ds_ctl_model.q_n, D1);
    idle();
    check(i_b2ds_ctl_model.oe_k, 1'h1);
    check(i_b2ds_ctl_model.q_k, {D0[35:9], E0[8:0]});
    check(i_b2ds_ctl_model.q_n, D1);
    idle();
    check(i_b2ds_ctl_model.oe_k, 1'h0);
  endtask : test_merge_read
  // write after idle gap, lane-masked rewrite, read of it next cycle
  task automatic test_turnaround;
    idle();
    i_b2ds_ctl_model.kcyc(1'h0, 1'h0, 6'h2a, ~DQ_IN, 4'hf, DQ_IN, 4'hf);
    i_b2ds_ctl_model.kcyc(1'h0, 1'h0, 6'h2a, D1, 4'h0, D0, 4'h0);
    i_b2ds_ctl_model.kcyc(1'h0, 1'h1, 6'h2a, E0, 4'hd, E1, 4'h7);
    idle();
    idle();
    idle();
    check(i_b2ds_ctl_model.oe_k, 1'h1);
    check(i_b2ds_ctl_model.q_k, {D1[35:18], E0[17:9], D1[8:0]});
    check(i_b2ds_ctl_model.q_n, {E1[35:27], D0[26:0]});
  endtask : test_turnaround
  initial begin
    RST_B = 1'h0;
    repeat (16) @(posedge REF_CLK);
    RST_B <= 1'h1;
    repeat (3) @(posedge REF_CLK);
    check(DQ_OE, 1'h0);
    check(DQ_OUT, 36'h0);
    test_merge_read();
    test_turnaround();
    test_done();
  end
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
endmodule : tb_top
`default_nettype wire
